/* File: qbsp_port.sv */
// Device side of a quad rate burst SRAM: separate read and write ports,
// shared address bus, two-word bursts and byte-lane write masking.
// Assumes the pin clocks run much slower than clk_sys (input clock period
// of at least eight system cycles) and that all pins are asynchronous to it.
`timescale 1ns/1ps
`default_nettype none

module qbsp_port
  import qbsp_pkg::*;
(
  // System clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Input clock pair.
  input wire logic kClk,
  input wire logic kClkBar,
  // Output clock pair.
  input wire logic cClk,
  input wire logic cClkBar,
  // Port selects.
  input wire logic readSel_n,
  input wire logic writeSel_n,
  // Shared address and write data.
  input wire logic [ADDR_W-1:0] sharedAddress,
  input wire logic [DATA_W-1:0] writeDataIn,
  input wire logic lane0WriteStrobe_n,
  input wire logic lane1WriteStrobe_n,
  input wire logic lane2WriteStrobe_n,
  input wire logic lane3WriteStrobe_n,
  // Read data.
  output logic [DATA_W-1:0] readDataOut,
  output logic readDataOutEn,
  // Output impedance.
  input wire logic [IMP_W-1:0] impedanceReference,
  output logic [IMP_W-1:0] driveImpedance,
  output logic impedanceSettled
);

  localparam int SYNC_W = 6 + LANES + ADDR_W + DATA_W + IMP_W;

  // Synchronised pin values.
  logic kS;
  logic kbS;
  logic cS;
  logic cbS;
  logic rdSelS_n;
  logic wrSelS_n;
  logic [LANES-1:0] strobeS_n;
  logic [ADDR_W-1:0] addrS;
  logic [DATA_W-1:0] dataS;
  logic [IMP_W-1:0] impS;

  qbsp_sync #(
    .W(SYNC_W)
  ) uSync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din({kClk, kClkBar, cClk, cClkBar, readSel_n, writeSel_n,
          lane3WriteStrobe_n, lane2WriteStrobe_n, lane1WriteStrobe_n, lane0WriteStrobe_n,
          sharedAddress, writeDataIn, impedanceReference}),
    .dout({kS, kbS, cS, cbS, rdSelS_n, wrSelS_n, strobeS_n, addrS, dataS, impS})
  );

  // Edge detection on the synchronised clocks.
  // The bar pins idle high, so one false rise follows reset; no sequencer
  // waits on a bar edge at that point, so it passes without effect.
  logic kPrev_r;
  logic kbPrev_r;
  logic cPrev_r;
  logic cbPrev_r;
  logic kRiseD_r;
  logic kbRiseD_r;
  logic singleClk_r;

  wire kRise = kS & ~kPrev_r;
  wire kbRise = kbS & ~kbPrev_r;
  wire cRise = cS & ~cPrev_r;
  wire cbRise = cbS & ~cbPrev_r;

  // With both output clocks held high the input pair times the outputs.
  wire outRise = singleClk_r ? kRiseD_r : cRise;
  wire outRiseBar = singleClk_r ? kbRiseD_r : cbRise;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      kPrev_r <= 1'b0;
      kbPrev_r <= 1'b0;
      cPrev_r <= 1'b0;
      cbPrev_r <= 1'b0;
      kRiseD_r <= 1'b0;
      kbRiseD_r <= 1'b0;
      singleClk_r <= 1'b0;
    end else begin
      kPrev_r <= kS;
      kbPrev_r <= kbS;
      cPrev_r <= cS;
      cbPrev_r <= cbS;
      kRiseD_r <= kRise;
      kbRiseD_r <= kbRise;
      if (kRise) begin
        singleClk_r <= cS & cbS;
      end
    end
  end

  // Read fetch: base word then the next word of the burst.
  logic [1:0] fetchCnt_r;
  logic [1:0] fetchCnt_nxt;
  logic [ADDR_W-1:0] rdBase_r;
  logic [DATA_W-1:0] fetchW0_r;
  logic [DATA_W-1:0] fetchW1_r;
  logic fetchValid_r;
  logic [DATA_W-1:0] memRdData;

  wire rdCmd = kRise & ~rdSelS_n;
  wire [ADDR_W-1:0] rdBurstAddr = rdBase_r + {{(ADDR_W-1){1'b0}}, 1'b1};
  wire memRdEn = (fetchCnt_r == FETCH_BASE) | (fetchCnt_r == FETCH_NEXT);
  wire [ADDR_W-1:0] memRdAddr = (fetchCnt_r == FETCH_BASE) ? rdBase_r : rdBurstAddr;
  wire fetchDone = fetchCnt_r == FETCH_LAST;

  always_comb begin
    fetchCnt_nxt = fetchCnt_r;
    if (rdCmd) begin
      fetchCnt_nxt = FETCH_BASE;
    end else if (fetchCnt_r != FETCH_IDLE) begin
      fetchCnt_nxt = fetchCnt_r + 2'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fetchCnt_r <= FETCH_IDLE;
      rdBase_r <= '0;
      fetchW0_r <= '0;
      fetchW1_r <= '0;
      fetchValid_r <= 1'b0;
    end else begin
      fetchCnt_r <= fetchCnt_nxt;
      if (rdCmd) begin
        rdBase_r <= addrS;
      end
      if (fetchCnt_r == FETCH_NEXT) begin
        fetchW0_r <= memRdData;
      end
      if (fetchDone) begin
        fetchW1_r <= memRdData;
      end
      // A fetch completing in a promoting cycle keeps its valid flag.
      if (fetchDone) begin
        fetchValid_r <= 1'b1;
      end else if (kRise) begin
        fetchValid_r <= 1'b0;
      end
    end
  end

  // Read output sequencing.
  qbsp_rd_e rdPhase_r;
  qbsp_rd_e rdPhase_nxt;
  logic armed_r;
  logic armed_nxt;
  logic [DATA_W-1:0] armW0_r;
  logic [DATA_W-1:0] armW1_r;
  logic [DATA_W-1:0] dout_nxt;
  logic oe_nxt;

  // A finished fetch moves to the output stage at the next input clock rise.
  wire promote = kRise & fetchValid_r;
  wire readIdle = ~fetchValid_r & ~armed_r & (fetchCnt_r == FETCH_IDLE);

  always_comb begin
    rdPhase_nxt = rdPhase_r;
    armed_nxt = armed_r;
    dout_nxt = readDataOut;
    oe_nxt = readDataOutEn;
    if (outRise && armed_r) begin
      dout_nxt = armW0_r;
      oe_nxt = 1'b1;
      rdPhase_nxt = RD_WORD0;
      armed_nxt = 1'b0;
    end else if (outRiseBar && rdPhase_r == RD_WORD0) begin
      dout_nxt = armW1_r;
      rdPhase_nxt = RD_WORD1;
    end
    if (promote) begin
      armed_nxt = 1'b1;
    end
    if (kRise && readIdle && rdPhase_r == RD_WORD1) begin
      oe_nxt = 1'b0;
      rdPhase_nxt = RD_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdPhase_r <= RD_IDLE;
      armed_r <= 1'b0;
      armW0_r <= '0;
      armW1_r <= '0;
      readDataOut <= '0;
      readDataOutEn <= 1'b0;
    end else begin
      rdPhase_r <= rdPhase_nxt;
      armed_r <= armed_nxt;
      readDataOut <= dout_nxt;
      readDataOutEn <= oe_nxt;
      if (promote) begin
        armW0_r <= fetchW0_r;
        armW1_r <= fetchW1_r;
      end
    end
  end

  // Write sequencing, independent of the read side.
  qbsp_wr_e wrState_r;
  qbsp_wr_e wrState_nxt;
  logic [ADDR_W-1:0] wrBase_r;
  logic [DATA_W-1:0] wrD0_r;
  logic [DATA_W-1:0] wrD1_r;
  logic [LANES-1:0] wrM0_r;
  logic [LANES-1:0] wrM1_r;

  // Only the first data word needs the write select low; the second is taken at the next bar rise whatever the select.
  wire wrCmd = kRise & ~wrSelS_n;
  wire wrSecond = kbRise & (wrState_r == WR_ADDR);
  wire [ADDR_W-1:0] wrBurstAddr = wrBase_r + {{(ADDR_W-1){1'b0}}, 1'b1};
  wire wrPut0 = wrState_r == WR_PUT0;
  wire wrPut1 = wrState_r == WR_PUT1;
  wire [ADDR_W-1:0] memWrAddr = wrPut1 ? wrBurstAddr : wrBase_r;
  wire [DATA_W-1:0] memWrData = wrPut1 ? wrD1_r : wrD0_r;
  // An all-inactive mask still walks both put states but enables no lane.
  wire [LANES-1:0] memWrLaneEn = ({LANES{wrPut0}} & wrM0_r) | ({LANES{wrPut1}} & wrM1_r);

  always_comb begin
    wrState_nxt = wrState_r;
    unique case (wrState_r)
      WR_IDLE: begin
        if (wrCmd) begin
          wrState_nxt = WR_ADDR;
        end
      end
      WR_ADDR: begin
        if (kbRise) begin
          wrState_nxt = WR_PUT0;
        end
      end
      WR_PUT0: begin
        wrState_nxt = WR_PUT1;
      end
      WR_PUT1: begin
        wrState_nxt = wrCmd ? WR_ADDR : WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wrState_r <= WR_IDLE;
      wrBase_r <= '0;
      wrD0_r <= '0;
      wrD1_r <= '0;
      wrM0_r <= '0;
      wrM1_r <= '0;
    end else begin
      wrState_r <= wrState_nxt;
      if (wrCmd) begin
        wrD0_r <= dataS;
        wrM0_r <= ~strobeS_n;
      end
      if (wrSecond) begin
        wrBase_r <= addrS;
        wrD1_r <= dataS;
        wrM1_r <= ~strobeS_n;
      end
    end
  end

  // Separate ports let a fetch and a put share the same system cycle.
  qbsp_mem uMem (
    .clk_sys(clk_sys),
    .wrAddr(memWrAddr),
    .wrData(memWrData),
    .wrLaneEn(memWrLaneEn),
    .rdEn(memRdEn),
    .rdAddr(memRdAddr),
    .rdData(memRdData)
  );

  // Impedance code and power-up settling count.
  logic [SETTLE_W-1:0] settleCnt_r;

  // Updates wait for a cycle in which the outputs are floating.
  // A fetched burst awaiting promotion counts as driving, so the code waits too.
  wire impUpdate = kRise & ~readDataOutEn & ~armed_r & ~fetchValid_r
    & (rdPhase_r == RD_IDLE);
  wire nonReadCycle = kRise & rdSelS_n;
  wire settleReached = settleCnt_r == SETTLE_W'(SETTLE_CYCLES);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      driveImpedance <= IMP_RST;
      settleCnt_r <= '0;
      impedanceSettled <= 1'b0;
    end else begin
      if (impUpdate) begin
        driveImpedance <= impS;
      end
      if (nonReadCycle && !settleReached) begin
        settleCnt_r <= settleCnt_r + SETTLE_W'(1);
      end
      impedanceSettled <= settleReached;
    end
  end

  // Every action above is gated by a sampled clock edge, so a stopped input
  // clock simply freezes the sequencers once their internal steps are done.

endmodule : qbsp_port
`default_nettype wire

/* File: qbsp_pkg.sv */
// Package of constants and types for the quad rate burst SRAM port.
// Assumes a single system clock; all pin timing is sampled into that clock.
package qbsp_pkg;

  // Wide variant geometry: 524,288 words of 36 bits.
  localparam int DATA_W = 36;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int ADDR_W = 19;
  localparam int DEPTH = 524288;
  // Narrow variant depth, for reference: 1,048,576 words of 18 bits.
  localparam int NARROW_DEPTH = 1048576;

  // Output impedance code carried on the impedance reference port.
  localparam int IMP_W = 6;
  localparam logic [IMP_W-1:0] IMP_RST = 6'h20;

  // Non-read input clock cycles before the output impedance is settled.
  localparam int SETTLE_CYCLES = 1024;
  localparam int SETTLE_W = 11;

  // System clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 20;

  // Read fetch step counter values.
  localparam logic [1:0] FETCH_IDLE = 2'h0;
  localparam logic [1:0] FETCH_BASE = 2'h1;
  localparam logic [1:0] FETCH_NEXT = 2'h2;
  localparam logic [1:0] FETCH_LAST = 2'h3;

  typedef enum logic [1:0] {RD_IDLE, RD_WORD0, RD_WORD1} qbsp_rd_e;
  typedef enum logic [1:0] {WR_IDLE, WR_ADDR, WR_PUT0, WR_PUT1} qbsp_wr_e;

endpackage : qbsp_pkg

/* File: qbsp_sync.sv */
// Two flip-flop synchroniser for a group of pin inputs.
// Assumes every bit comes from outside the clk_sys domain.
`timescale 1ns/1ps
`default_nettype none
module qbsp_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pin side and synchronised side.
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      dout <= '0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end

endmodule : qbsp_sync
`default_nettype wire

/* File: qbsp_mem.sv */
// Memory array with one registered read port and one lane-masked write port.
// Assumes the caller sequences the two words of each burst.
`timescale 1ns/1ps
`default_nettype none
module qbsp_mem
  import qbsp_pkg::*;
(
  // Clock.
  input wire logic clk_sys,
  // Write port.
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic [LANES-1:0] wrLaneEn,
  // Read port.
  input wire logic rdEn,
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData
);

  // Each lane keeps its own array, so a lane whose enable is clear is never touched.
  for (genvar g = 0; g < LANES; g++) begin : gLane
    logic [LANE_W-1:0] laneMem [0:DEPTH-1];

    always_ff @(posedge clk_sys) begin
      if (wrLaneEn[g]) begin
        laneMem[wrAddr] <= wrData[g*LANE_W +: LANE_W];
      end
    end

    always_ff @(posedge clk_sys) begin
      if (rdEn) begin
        rdData[g*LANE_W +: LANE_W] <= laneMem[rdAddr];
      end
    end
  end

endmodule : qbsp_mem
`default_nettype wire

/* File: qbsp_port_properties.sv */
// Concurrent checks on the read data, deselect and impedance ports of the port.
// Assumes an input clock period of eight clk_sys cycles.
`timescale 1ns/1ps
`default_nettype none
module qbsp_port_properties
  import qbsp_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Observed ports.
  input wire logic readSel_n,
  input wire logic [DATA_W-1:0] readDataOut,
  input wire logic readDataOutEn,
  input wire logic [IMP_W-1:0] driveImpedance,
  input wire logic impedanceSettled
);
  logic [7:0] idleCnt_r;
  logic [13:0] upCnt_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idleCnt_r <= 8'h00;
      upCnt_r <= 14'h0000;
    end else begin
      idleCnt_r <= readSel_n ? idleCnt_r + {7'h00, ~&idleCnt_r} : 8'h00;
      upCnt_r <= upCnt_r + {13'h0000, ~&upCnt_r};
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence burst_on_s;
    readDataOutEn [*6];
  endsequence

  burst_hold_a: assert property ($rose(readDataOutEn) |-> burst_on_s)
    else $error("read burst shorter than two words");
  read_start_a: assert property ($rose(readDataOutEn) |-> !$past(readSel_n, 12))
    else $error("read data without a read command");
  read_stop_a: assert property ($fell(readDataOutEn) |-> $past(readSel_n, 8))
    else $error("outputs released while a read was pending");
  word_pace_a: assert property (readDataOutEn && !$stable(readDataOut) |=>
    ($stable(readDataOut) || !readDataOutEn) [*3]) else $error("read words change too fast");
  idle_dark_a: assert property (idleCnt_r > 8'h18 |-> !readDataOutEn)
    else $error("outputs driven without reads");
  imp_quiet_a: assert property (!$stable(driveImpedance) |->
    !readDataOutEn && !$past(readDataOutEn))
    else $error("impedance changed while driving");
  settle_keep_a: assert property (impedanceSettled |=> impedanceSettled)
    else $error("settled flag dropped");
  settle_need_a: assert property ($rose(impedanceSettled) |-> upCnt_r > 14'h1F80)
    else $error("settled flag rose too early");
endmodule : qbsp_port_properties

bind qbsp_port qbsp_port_properties u_qbsp_port_properties (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .readSel_n(readSel_n),
  .readDataOut(readDataOut),
  .readDataOutEn(readDataOutEn),
  .driveImpedance(driveImpedance),
  .impedanceSettled(impedanceSettled)
);
`default_nettype wire

/* File: qbsp_ctrl_model.sv */
// Behavioural memory controller driving the pin side of the port.
// Assumes one input clock period is eight clk_sys cycles.
`timescale 1ns/1ps
`default_nettype none
module qbsp_ctrl_model
  import qbsp_pkg::*;
(
  // System clock.
  input wire logic clk_sys,
  // Clock pins.
  output logic kClk,
  output logic kClkBar,
  output logic cClk,
  output logic cClkBar,
  // Command and write pins.
  output logic readSel_n,
  output logic writeSel_n,
  output logic [ADDR_W-1:0] sharedAddress,
  output logic [DATA_W-1:0] writeDataIn,
  output logic [LANES-1:0] strobe_n,
  // Read pins.
  input wire logic [DATA_W-1:0] readDataOut,
  input wire logic readDataOutEn
);
  logic single = 1'b0;
  int kCount = 0;
  logic [DATA_W:0] seen [int];

  initial begin
    {kClk, kClkBar, cClk, cClkBar} = 4'h5;
    {readSel_n, writeSel_n} = 2'h3;
    sharedAddress = '0;
    writeDataIn = '0;
    strobe_n = 4'hF;
  end

  // Samples enable and data once the word of an output clock edge has settled.
  task automatic mark(input int slot);
    fork
      begin
        repeat (4) @(posedge clk_sys);
        #1 seen[slot] = {readDataOutEn, readDataOut};
      end
    join_none
  endtask : mark

  // One input clock period; unless single is set, the output clocks lag by two cycles, as board flight time would; with single set both stay high.
  task automatic cyc(input logic rd, input logic [ADDR_W-1:0] ra, input logic wr,
      input logic [ADDR_W-1:0] wa, input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1,
      input logic [LANES-1:0] sb, output int n);
    @(posedge clk_sys);
    n = kCount;
    kClk <= 1'b1;
    kClkBar <= 1'b0;
    readSel_n <= !rd;
    writeSel_n <= !wr;
    sharedAddress <= ra;
    writeDataIn <= wr ? d0 : ~writeDataIn;
    strobe_n <= sb;
    if (single) mark(2 * n);
    repeat (2) @(posedge clk_sys);
    cClk <= 1'b1;
    cClkBar <= single;
    if (!single) mark(2 * n);
    repeat (2) @(posedge clk_sys);
    kClk <= 1'b0;
    kClkBar <= 1'b1;
    sharedAddress <= wa;
    writeDataIn <= wr ? d1 : ~writeDataIn;
    if (single) mark(2 * n + 1);
    repeat (2) @(posedge clk_sys);
    cClk <= single;
    cClkBar <= 1'b1;
    if (!single) mark(2 * n + 1);
    @(posedge clk_sys);
    kCount++;
  endtask : cyc
endmodule : qbsp_ctrl_model
`default_nettype wire

/* File: qbsp_port_test.sv */
// Self-checking testbench of the port with a behavioural controller on its pins.
// Assumes the port and its bound checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin fails++; \
  $display("[FAIL] %0t %s", $time, msg); end end
module qbsp_port_test;
  import qbsp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [IMP_W-1:0] impedanceReference = IMP_RST;
  logic kClk, kClkBar, cClk, cClkBar, readSel_n, writeSel_n, readDataOutEn, impedanceSettled;
  logic [ADDR_W-1:0] sharedAddress;
  logic [DATA_W-1:0] writeDataIn, readDataOut;
  logic [LANES-1:0] strobe_n;
  logic [IMP_W-1:0] driveImpedance;
  int fails = 0;
  int comparisons = 0;

  always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

  qbsp_ctrl_model u_qbsp_ctrl_model (.clk_sys(clk_sys), .kClk(kClk), .kClkBar(kClkBar),
    .cClk(cClk), .cClkBar(cClkBar), .readSel_n(readSel_n), .writeSel_n(writeSel_n),
    .sharedAddress(sharedAddress), .writeDataIn(writeDataIn), .strobe_n(strobe_n),
    .readDataOut(readDataOut), .readDataOutEn(readDataOutEn));

  qbsp_port u_qbsp_port (.clk_sys(clk_sys), .rst_n(rst_n), .kClk(kClk), .kClkBar(kClkBar),
    .cClk(cClk), .cClkBar(cClkBar), .readSel_n(readSel_n), .writeSel_n(writeSel_n),
    .sharedAddress(sharedAddress), .writeDataIn(writeDataIn),
    .lane0WriteStrobe_n(strobe_n[0]), .lane1WriteStrobe_n(strobe_n[1]),
    .lane2WriteStrobe_n(strobe_n[2]), .lane3WriteStrobe_n(strobe_n[3]),
    .readDataOut(readDataOut), .readDataOutEn(readDataOutEn),
    .impedanceReference(impedanceReference), .driveImpedance(driveImpedance),
    .impedanceSettled(impedanceSettled));

  function automatic logic [DATA_W-1:0] pat(input logic [ADDR_W-1:0] a);
    return {a[3:0], ~a[15:0], a[15:0]};
  endfunction : pat

  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic idle(input int k);
    int n;
    repeat (k) u_qbsp_ctrl_model.cyc(1'b0, '0, 1'b0, '0, '0, '0, 4'hF, n);
  endtask : idle

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0,
      input logic [DATA_W-1:0] d1, input logic [LANES-1:0] sb);
    int n;
    u_qbsp_ctrl_model.cyc(1'b0, '0, 1'b1, a, d0, d1, sb, n);
  endtask : wr

  task automatic expect_rd(input int n, input logic [DATA_W-1:0] w0,
      input logic [DATA_W-1:0] w1, input string msg);
    `CHK(u_qbsp_ctrl_model.seen[2 * n + 2], {1'b1, w0}, msg)
    `CHK(u_qbsp_ctrl_model.seen[2 * n + 3], {1'b1, w1}, msg)
  endtask : expect_rd

  task automatic test_reset();
    `CHK(readDataOutEn, 1'b0, "outputs driven after reset")
    `CHK(driveImpedance, IMP_RST, "impedance reset code")
    `CHK(impedanceSettled, 1'b0, "settled after reset")
    $display("test reset done");
  endtask : test_reset

  task automatic test_burst();
    int n0, n1;
    wr(19'h7FFFF, pat(19'h7FFFF), pat(19'h00000), 4'h0);
    wr(19'h00100, pat(19'h00100), pat(19'h00101), 4'h0);
    u_qbsp_ctrl_model.cyc(1'b1, 19'h7FFFF, 1'b1, 19'h00200, pat(19'h00200),
      pat(19'h00201), 4'h0, n0);
    u_qbsp_ctrl_model.cyc(1'b1, 19'h00100, 1'b0, '0, '0, '0, 4'hF, n1);
    u_qbsp_ctrl_model.cyc(1'b1, 19'h00200, 1'b0, '0, '0, '0, 4'hF, n1);
    idle(3);
    expect_rd(n0, pat(19'h7FFFF), pat(19'h00000), "wrapped burst");
    expect_rd(n0 + 1, pat(19'h00100), pat(19'h00101), "back to back burst");
    expect_rd(n1, pat(19'h00200), pat(19'h00201), "concurrent write");
    `CHK(u_qbsp_ctrl_model.seen[2 * n1 + 4][DATA_W], 1'b0, "no deselect")
    $display("test burst done");
  endtask : test_burst

  task automatic test_lanes();
    logic [LANES-1:0] sbs [5] = '{4'hE, 4'hD, 4'h3, 4'hF, 4'h0};
    logic [DATA_W-1:0] e;
    logic [ADDR_W-1:0] a;
    int n;
    for (int i = 0; i < 5; i++) begin
      a = 19'h00300 + 19'(2 * i);
      e = {{9{sbs[i][3]}}, {9{sbs[i][2]}}, {9{sbs[i][1]}}, {9{sbs[i][0]}}};
      wr(a, '1, '1, 4'h0);
      wr(a, '0, '0, sbs[i]);
      u_qbsp_ctrl_model.cyc(1'b0, '0, 1'b0, a, '1, '1, 4'h0, n);
      u_qbsp_ctrl_model.cyc(1'b1, a, 1'b0, '0, '0, '0, 4'hF, n);
      idle(2);
      expect_rd(n, e, e, "lane mask");
    end
    $display("test lanes done");
  endtask : test_lanes

  task automatic test_single();
    int n;
    u_qbsp_ctrl_model.single = 1'b1;
    idle(2);
    u_qbsp_ctrl_model.cyc(1'b1, 19'h00100, 1'b0, '0, '0, '0, 4'hF, n);
    idle(3);
    expect_rd(n, pat(19'h00100), pat(19'h00101), "single clock read");
    u_qbsp_ctrl_model.single = 1'b0;
    idle(2);
    $display("test single done");
  endtask : test_single

  task automatic test_imp();
    int i;
    `CHK(impedanceSettled, 1'b0, "settled too early")
    impedanceReference <= 6'h15;
    for (i = 0; i < 40 && driveImpedance !== 6'h15; i++) idle(1);
    `CHK(driveImpedance, 6'h15, "impedance code not taken")
    for (i = 0; i < 1100 && impedanceSettled !== 1'b1; i++) idle(1);
    if (impedanceSettled !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t settle wait ran out", $time);
      summarize();
    end
    $display("test impedance done");
  endtask : test_imp

  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    test_reset();
    test_burst();
    test_lanes();
    test_single();
    test_imp();
    summarize();
  end
endmodule : qbsp_port_test
`default_nettype wire
